// File: bench/i2cm_ctrl_sva.sv
`timescale 1ns/1ps
// port-level properties of the master controller
module i2cm_ctrl_sva (
  input wire clk,
  input wire rst_n,
  input wire soft_reset,
  input wire scl_oe,
  input wire ctl_wr,
  input wire ctl_service_flag,
  input wire service_flag,
  input wire [7:0] status_code_reg,
  input wire start_request,
  input wire stop_request,
  input wire ack_enable,
  input wire bus_busy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n || soft_reset);
  status_load_a:
    assert property ($changed(status_code_reg) &&
      status_code_reg != 8'hF8 |-> $rose(service_flag))
      else $error("status moved without flag");
  flag_code_a:
    assert property ($rose(service_flag) |-> status_code_reg != 8'hF8)
      else $error("flag set with idle status");
  bus_stall_a:
    assert property ((service_flag && status_code_reg inside
      {8'h08, 8'h10, 8'h28, 8'h30, 8'h48, 8'h50}) [*3] |-> scl_oe)
      else $error("clock line free while flag set");
  flag_clear_a:
    assert property (service_flag && ctl_wr && !ctl_service_flag
      |=> !service_flag) else $error("flag not cleared");
  start_code_a:
    assert property ($rose(service_flag) && (status_code_reg == 8'h08 ||
      status_code_reg == 8'h10) |-> $past(start_request, 2))
      else $error("start status without request");
  start_done_a:
    assert property ($fell(start_request) |-> ##[0:3] service_flag)
      else $error("start done without flag");
  stop_done_a:
    assert property ($rose(stop_request) |-> ##[1:1000] !stop_request)
      else $error("stop request never cleared");
  stop_idle_a:
    assert property ($fell(stop_request) && !start_request |->
      ##[0:50] !bus_busy) else $error("bus busy after stop");
  rx_ack_a:
    assert property ($rose(service_flag) && status_code_reg[7:4] == 4'h5
      |-> ack_enable == (status_code_reg == 8'h50))
      else $error("receive ack differs from ack enable");
endmodule // i2cm_ctrl_sva
bind i2cm_ctrl i2cm_ctrl_sva chk (.clk(clk), .rst_n(rst_n),
  .soft_reset(soft_reset), .scl_oe(scl_oe), .ctl_wr(ctl_wr),
  .ctl_service_flag(ctl_service_flag), .service_flag(service_flag),
  .status_code_reg(status_code_reg), .start_request(start_request),
  .stop_request(stop_request), .ack_enable(ack_enable),
  .bus_busy(bus_busy));

// File: bench/i2cm_ctrl_tb_top.sv
`timescale 1ns/1ps
// directed bench: write, restart, read and stop against one slave
module i2cm_ctrl_tb_top;
  localparam [6:0] SLV = 7'h2A;
  localparam [6:0] XHI = 7'h79;
  localparam [7:0] XLO = 8'h9C;
  reg clk, rst_n, ctl_wr, c_sta, c_stp, c_ack, tx_valid, nack;
  reg [7:0] tx_data;
  wire scl_oe, sda_oe, s_oe, tx_ready, service_flag, start_request;
  wire stop_request, ack_enable, bus_busy, scl_o, sda_o;
  wire [7:0] status_code_reg, data_byte_reg, got;
  wire scl = ~scl_oe;
  wire sda = ~sda_oe & ~s_oe;
  integer fails, checks;
  i2cm_ctrl uut (.clk(clk), .rst_n(rst_n), .scl_in(scl), .scl_out(scl_o),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_o), .sda_oe(sda_oe),
    .ctl_wr(ctl_wr), .ctl_start_request(c_sta), .ctl_stop_request(c_stp),
    .ctl_ack_enable(c_ack), .ctl_service_flag(1'b0), .soft_reset(1'b0),
    .own_addr(7'h55), .gc_enable(1'b0), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .service_flag(service_flag),
    .status_code_reg(status_code_reg), .data_byte_reg(data_byte_reg),
    .start_request(start_request), .stop_request(stop_request),
    .ack_enable(ack_enable), .bus_busy(bus_busy));
  i2cm_slave #(.ADDR(SLV), .XHI(XHI), .XLO(XLO)) slave (.scl(scl),
    .sda(sda), .nack(nack), .sda_oe(s_oe), .last(got));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task chk(input string n, input [7:0] e, input [7:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("FAIL %s exp %h got %h", n, e, g);
      end
    end
  endtask
  // control write with flag clear, then wait for the flag
  task step(input s, input p, input a, input [7:0] e);
    integer i;
    begin
      @(posedge clk);
      ctl_wr <= 1'b1;
      c_sta <= s;
      c_stp <= p;
      c_ack <= a;
      @(posedge clk);
      ctl_wr <= 1'b0;
      #1; // let the clear settle before polling
      i = 0;
      while (service_flag !== 1'b1 && i < 4000) begin
        @(posedge clk);
        #1;
        i = i + 1;
      end
      chk("flag", 8'h01, {7'h00, service_flag});
      chk("status", e, status_code_reg);
    end
  endtask
  task push(input [7:0] d);
    begin
      @(posedge clk);
      tx_data <= d;
      tx_valid <= 1'b1;
      @(posedge clk);
      tx_valid <= 1'b0;
    end
  endtask
  task t_fifo;
    begin
      chk("reset status", 8'hF8, status_code_reg);
      push({SLV, 1'b0});
      push(8'h3C);
      push(8'h5A);
      push({7'h11, 1'b1});
      @(posedge clk);
      #1;
      chk("tx_ready", 8'h00, {7'h00, tx_ready});
      $display("test fifo done");
    end
  endtask
  task t_write;
    begin
      step(1'b1, 1'b0, 1'b1, 8'h08);
      step(1'b0, 1'b0, 1'b1, 8'h18);
      step(1'b0, 1'b0, 1'b1, 8'h28);
      chk("slave byte", 8'h3C, got);
      nack <= 1'b1;
      step(1'b0, 1'b0, 1'b1, 8'h30);
      nack <= 1'b0;
      step(1'b1, 1'b0, 1'b1, 8'h10);
      $display("test write done");
    end
  endtask
  task t_read;
    begin
      step(1'b0, 1'b0, 1'b1, 8'h48);
      step(1'b1, 1'b1, 1'b1, 8'h08);
      push({SLV, 1'b1});
      step(1'b0, 1'b0, 1'b1, 8'h40);
      step(1'b0, 1'b0, 1'b1, 8'h50);
      chk("rx byte", 8'hA5, data_byte_reg);
      step(1'b0, 1'b0, 1'b0, 8'h58);
      chk("rx byte", 8'hA5, data_byte_reg);
      $display("test read done");
    end
  endtask
  task t_stop;
    integer i;
    begin
      @(posedge clk);
      ctl_wr <= 1'b1;
      c_stp <= 1'b1;
      @(posedge clk);
      ctl_wr <= 1'b0;
      i = 0;
      while ((bus_busy !== 1'b0 || stop_request !== 1'b0) && i < 1000) begin
        @(posedge clk);
        #1;
        i = i + 1;
      end
      chk("stop_request", 8'h00, {7'h00, stop_request});
      chk("bus_busy", 8'h00, {7'h00, bus_busy});
      chk("status", 8'hF8, status_code_reg);
      chk("drive level", 8'h00, {6'h00, scl_o, sda_o});
      $display("test stop done");
    end
  endtask
  task t_ten;
    begin
      push({XHI, 1'b0});
      push(XLO);
      push({XHI, 1'b1});
      step(1'b1, 1'b0, 1'b1, 8'h08);
      step(1'b0, 1'b0, 1'b1, 8'h18);
      step(1'b0, 1'b0, 1'b1, 8'hD0);
      step(1'b1, 1'b0, 1'b1, 8'h10);
      step(1'b0, 1'b0, 1'b1, 8'h40);
      $display("test ten-bit done");
    end
  endtask
  task final_report;
    begin
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // main sequence
  initial begin
    fails = 0;
    checks = 0;
    {rst_n, ctl_wr, c_sta, c_stp, c_ack, tx_valid, nack} = 7'h00;
    tx_data = 8'h00;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_fifo;
    t_write;
    t_read;
    t_stop;
    t_ten;
    t_stop;
    final_report;
  end
  // watchdog
  initial begin
    repeat (60000) @(posedge clk);
    fails = fails + 1;
    $display("FAIL watchdog exp done got hang");
    final_report;
  end
endmodule // i2cm_ctrl_tb_top

// File: bench/i2cm_slave.sv
`timescale 1ns/1ps
// slave model: acks its address, takes writes, serves 8'hA5 on reads
module i2cm_slave #(
  parameter [6:0] ADDR = 7'h2A,
  parameter [6:0] XHI = 7'h79,
  parameter [7:0] XLO = 8'h9C
) (
  input wire scl,
  input wire sda,
  input wire nack,
  output reg sda_oe,
  output reg [7:0] last
);
  integer bc;
  reg [7:0] sh;
  reg [7:0] tx;
  reg adr, rd, sel, done, ten_p, ten_sel;
  initial begin
    bc = -1;
    {sda_oe, adr, rd, sel, done, ten_p, ten_sel} = 7'h00;
    last = 8'h00;
    sh = 8'h00;
    tx = 8'hFF;
  end
  // start opens an address phase, stop deselects
  always @(sda) begin
    if (scl === 1'b1) begin
      bc = -1;
      adr = ~sda;
      sel = 1'b0;
      done = 1'b0;
      if (sda) ten_sel = 1'b0;
      sda_oe = 1'b0;
    end
  end
  // bits sampled while the clock is high; master nack ends a read
  always @(posedge scl) begin
    if (bc >= 0 && bc < 8)
      sh = {sh[6:0], sda};
    else if (bc == 8 && rd && !adr)
      done = sda;
  end
  // ack and read data change only after the falling edge
  always @(negedge scl) begin
    if (bc == 7) begin
      if (adr) begin
        rd = sh[0];
        sel = (sh[7:1] == ADDR) ||
              (sh[7:1] == XHI && (!rd || ten_sel));
        ten_p = (sh[7:1] == XHI) && !rd;
        ten_sel = ten_sel && rd;
      end else if (ten_p) begin
        sel = (sh == XLO);
        ten_sel = sel;
        ten_p = 1'b0;
      end else if (!rd)
        last = sh;
      sda_oe = sel & (adr | !rd) & !nack;
      bc = 8;
    end else if (bc == 8) begin
      bc = 0;
      adr = 1'b0;
      tx = 8'hA5;
      sda_oe = sel & rd & !done & !tx[7];
    end else begin
      bc = bc + 1;
      if (bc > 0)
        tx = {tx[6:0], 1'b1};
      sda_oe = sel & rd & !adr & !done & !tx[7];
    end
  end
endmodule // i2cm_slave

// File: rtl/i2cm_ctrl.v
`timescale 1ns/1ps
`include "i2cm_map.vh"
////////////////////////////////////////////////////////////////////////////
// Operation
// - a repeated start reports 10h instead of 08h
// - after each sent data byte set flag, 28h on ack, 30h on nack
// - from 28h/30h clear flag to send next byte, restart, stop or both
// - at 38h a clear goes idle; with start set, start when bus frees
// - a stop request drives stop, clears itself, returns to idle
// - after 40h a clear receives a byte, acked per ack_enable
// - after 48h start, stop or both give restart, stop, stop then start
// - ten-bit restart with read reports 40h on ack, 48h on nack
// - lost to own write or general call: ack, 68h/78h, slave receive
// - lost to own read address: 0B0h, slave transmit, last byte marked
// - a repeated start in master receive reports 10h
// - after 50h a clear receives next byte, acked per ack_enable
// - after 58h start, stop or both give restart, stop, stop then start
// - loss during the nack bit reports 38h as in transmit
// - last received byte is nacked, then stop request ends transfer
// - start request waits for a free bus, sends start, posts 08h
module i2cm_ctrl (
  input wire clk,
  input wire rst_n,
  input wire scl_in,
  output wire scl_out,
  output wire scl_oe,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  input wire ctl_wr,
  input wire ctl_start_request,
  input wire ctl_stop_request,
  input wire ctl_ack_enable,
  input wire ctl_service_flag,
  input wire soft_reset,
  input wire [6:0] own_addr,
  input wire gc_enable,
  input wire [7:0] tx_data,
  input wire tx_valid,
  output wire tx_ready,
  output wire service_flag,
  output wire [7:0] status_code_reg,
  output wire [7:0] data_byte_reg,
  output wire start_request,
  output wire stop_request,
  output wire ack_enable,
  output wire bus_busy
);
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_START = 7'h02;
  localparam [6:0] S_BYTE = 7'h04;
  localparam [6:0] S_STOP = 7'h08;
  localparam [6:0] S_WAIT = 7'h10;
  localparam [6:0] S_LOAD = 7'h20;
  localparam [6:0] S_SLV = 7'h40;
  localparam [31:0] QTR_FULL = `I2CM_QTR_CYC - 1;
  localparam [4:0] QTR_LAST = QTR_FULL[4:0];

  reg [6:0] state_q;
  reg [1:0] phase_q;
  reg [4:0] qcnt_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg [7:0] txsh_q;
  reg [7:0] status_q;
  reg [7:0] data_q;
  reg flag_q, sta_q, stp_q, aak_q;
  reg ack_bit_q, ack_rx_q, ack_drv_q;
  reg restart_q, hold_q, addr_byte_q, rx_mode_q, byte_rx_q;
  reg ten_q, ext_q, slv_q, slv_tx_q, slv_addr_q, gc_q, last_q;
  reg busy_q, low_q, scl_oe_q, sda_oe_q;
  reg scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
  reg scl_pull, sda_pull;
  wire fifo_valid;
  wire [7:0] fifo_data;
  wire fifo_pop;
  wire scl_rise, scl_fall, start_seen, stop_seen;
  wire in_master, tick, advance, slv_release, arb_lost, clr_now;
  wire [1:0] hit;

  // matches a received address byte: bit 1 general call, bit 0 selected
  function [1:0] addr_hit;
    input [7:0] b;
    input [6:0] own;
    input gc_en;
    reg gc;
    begin
      gc = (b[7:1] == `I2CM_GC_ADDR) & gc_en & ~b[0];
      addr_hit = {gc, gc | (b[7:1] == own)};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // transmit byte buffer between software and the shifter
  i2cm_fifo #(
    .WIDTH(`I2CM_FIFO_W),
    .DEPTH(`I2CM_FIFO_D),
    .AW(`I2CM_FIFO_AW)
  ) u_txbuf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers; the first stage feeds only the second
  always @(posedge clk) begin
    if (!rst_n) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  // bus events seen on the synchronised lines
  assign scl_rise = scl_s2 & ~scl_s3;
  assign scl_fall = ~scl_s2 & scl_s3;
  assign start_seen = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  assign stop_seen = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
  assign hit = addr_hit(sh_q, own_addr, gc_enable);

  // quarter-bit timer; the rising phase waits for a stretched clock
  assign in_master = (state_q == S_START) | (state_q == S_BYTE) |
                     (state_q == S_STOP);
  assign tick = (qcnt_q == 5'h00);
  assign advance = tick & in_master &
                   ((phase_q != `I2CM_PH_RISE) | scl_s2);
  assign slv_release = (state_q == S_SLV) & hold_q & tick;
  assign fifo_pop = (state_q == S_LOAD) & fifo_valid;
  assign clr_now = ctl_wr & ~ctl_service_flag & flag_q;
  // a released line read low while we meant it high
  assign arb_lost = (state_q == S_BYTE) & advance &
                    (phase_q == `I2CM_PH_HIGH) & ~sda_s2 &
                    ((bit_q != `I2CM_BIT_ACK) ?
                     (~byte_rx_q & txsh_q[7]) :
                     (byte_rx_q & ~ack_bit_q));

  always @(posedge clk) begin
    if (!rst_n) begin
      qcnt_q <= QTR_LAST;
    end else if (!(in_master | ((state_q == S_SLV) & hold_q)) |
                 advance | slv_release) begin
      qcnt_q <= QTR_LAST;
    end else if (!tick) begin
      qcnt_q <= qcnt_q - 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // line pulls decoded from state and phase
  always @* begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    case (state_q)
      S_START: begin
        scl_pull = (phase_q == `I2CM_PH_LOW) | (phase_q == `I2CM_PH_FALL);
        sda_pull = phase_q[1];
      end
      S_BYTE: begin
        scl_pull = (phase_q == `I2CM_PH_LOW) | (phase_q == `I2CM_PH_FALL);
        if (bit_q == `I2CM_BIT_ACK) begin
          sda_pull = byte_rx_q & ack_bit_q;
        end else begin
          sda_pull = ~byte_rx_q & ~txsh_q[7];
        end
      end
      S_STOP: begin
        scl_pull = (phase_q == `I2CM_PH_LOW);
        sda_pull = (phase_q != `I2CM_PH_FALL);
      end
      S_WAIT, S_LOAD: begin
        scl_pull = hold_q;
      end
      S_SLV: begin
        scl_pull = hold_q;
        if (slv_tx_q) begin
          sda_pull = (bit_q < `I2CM_BIT_ACK) & ~txsh_q[7];
        end else begin
          sda_pull = ack_drv_q;
        end
      end
      default: begin
        scl_pull = 1'b0;
      end
    endcase
  end

  // open-drain drivers: enable high pulls the line low
  always @(posedge clk) begin
    if (!rst_n) begin
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      low_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      scl_oe_q <= scl_pull;
      sda_oe_q <= sda_pull;
      low_q <= 1'b0;
      if (start_seen) begin
        busy_q <= 1'b1;
      end else if (stop_seen) begin
        busy_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transfer sequencer
  always @(posedge clk) begin
    if (!rst_n || soft_reset) begin
      state_q <= S_IDLE;
      phase_q <= `I2CM_PH_LOW;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      txsh_q <= 8'h00;
      status_q <= `I2CM_ST_NOINFO;
      data_q <= 8'h00;
      flag_q <= 1'b0;
      sta_q <= 1'b0;
      stp_q <= 1'b0;
      aak_q <= 1'b0;
      ack_bit_q <= 1'b0;
      ack_rx_q <= 1'b0;
      ack_drv_q <= 1'b0;
      restart_q <= 1'b0;
      hold_q <= 1'b0;
      addr_byte_q <= 1'b0;
      rx_mode_q <= 1'b0;
      byte_rx_q <= 1'b0;
      ten_q <= 1'b0;
      ext_q <= 1'b0;
      slv_q <= 1'b0;
      slv_tx_q <= 1'b0;
      slv_addr_q <= 1'b0;
      gc_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      // software clear first so that a same-cycle set wins
      if (clr_now) begin
        flag_q <= 1'b0;
      end
      case (state_q)
        S_IDLE: begin
          if (sta_q && !busy_q && !start_seen) begin
            state_q <= S_START;
            phase_q <= `I2CM_PH_HIGH;
            restart_q <= 1'b0;
          end
        end
        S_START: begin
          if (advance) begin
            phase_q <= phase_q + 2'h1;
            if (phase_q == `I2CM_PH_FALL) begin
              flag_q <= 1'b1;
              status_q <= restart_q ? `I2CM_ST_RESTART :
                          `I2CM_ST_START;
              sta_q <= 1'b0;
              restart_q <= 1'b1;
              addr_byte_q <= 1'b1;
              ext_q <= 1'b0;
              hold_q <= 1'b1;
              state_q <= S_WAIT;
            end
          end
        end
        S_STOP: begin
          if (advance) begin
            phase_q <= phase_q + 2'h1;
            if (phase_q == `I2CM_PH_FALL) begin
              stp_q <= 1'b0;
              status_q <= `I2CM_ST_NOINFO;
              restart_q <= 1'b0;
              hold_q <= 1'b0;
              state_q <= S_IDLE;
            end
          end
        end
        S_BYTE: begin
          if (advance) begin
            phase_q <= phase_q + 2'h1;
            if (phase_q == `I2CM_PH_HIGH) begin
              if (bit_q != `I2CM_BIT_ACK) begin
                sh_q <= {sh_q[6:0], sda_s2};
              end else begin
                ack_rx_q <= ~sda_s2;
              end
              if (arb_lost && addr_byte_q) begin
                state_q <= S_SLV;
                hold_q <= 1'b0; // no stall of the winning master until our address ack ends
                slv_addr_q <= 1'b1;
                slv_tx_q <= 1'b0;
                bit_q <= bit_q + 4'h1;
                restart_q <= 1'b0;
              end else if (arb_lost) begin
                flag_q <= 1'b1;
                hold_q <= 1'b0; // lines released after a loss
                status_q <= `I2CM_ST_ARB;
                restart_q <= 1'b0;
                state_q <= S_WAIT;
              end
            end else if (phase_q == `I2CM_PH_FALL) begin
              if (bit_q == `I2CM_BIT_ACK) begin
                flag_q <= 1'b1;
                hold_q <= 1'b1;
                state_q <= S_WAIT;
                if (addr_byte_q) begin
                  addr_byte_q <= 1'b0;
                  ext_q <= ten_q & ~rx_mode_q;
                  if (rx_mode_q) begin
                    status_q <= ack_rx_q ? `I2CM_ST_AR_ACK :
                                `I2CM_ST_AR_NACK;
                  end else begin
                    status_q <= ack_rx_q ? `I2CM_ST_AW_ACK :
                                `I2CM_ST_AW_NACK;
                  end
                end else if (ext_q) begin
                  ext_q <= 1'b0;
                  status_q <= ack_rx_q ? `I2CM_ST_XA_ACK :
                              `I2CM_ST_XA_NACK;
                end else if (byte_rx_q) begin
                  data_q <= sh_q;
                  status_q <= ack_bit_q ? `I2CM_ST_RX_ACK :
                              `I2CM_ST_RX_NACK;
                end else begin
                  status_q <= ack_rx_q ? `I2CM_ST_TX_ACK :
                              `I2CM_ST_TX_NACK;
                end
              end else begin
                bit_q <= bit_q + 4'h1;
                txsh_q <= {txsh_q[6:0], 1'b0};
              end
            end
          end
        end
        S_WAIT: begin
          if (clr_now) begin
            phase_q <= `I2CM_PH_LOW;
            bit_q <= 4'h0;
            if ((status_q == `I2CM_ST_ARB) ||
                (status_q == `I2CM_ST_STX_NACK) ||
                (status_q == `I2CM_ST_STX_LAST) ||
                (status_q == `I2CM_ST_SRX_NACK) ||
                (status_q == `I2CM_ST_GRX_NACK)) begin
              hold_q <= 1'b0;
              state_q <= S_IDLE;
            end else if ((status_q == `I2CM_ST_SW) ||
                         (status_q == `I2CM_ST_SGC) ||
                         (status_q == `I2CM_ST_SRX_ACK) ||
                         (status_q == `I2CM_ST_GRX_ACK)) begin
              ack_bit_q <= ctl_ack_enable;
              slv_tx_q <= 1'b0;
              state_q <= S_SLV;
            end else if ((status_q == `I2CM_ST_SR) ||
                         (status_q == `I2CM_ST_STX_ACK)) begin
              last_q <= ~ctl_ack_enable;
              slv_q <= 1'b1;
              state_q <= S_LOAD;
            end else if (ctl_stop_request) begin
              state_q <= S_STOP;
            end else if (ctl_start_request) begin
              state_q <= S_START;
            end else if ((status_q == `I2CM_ST_AR_ACK) ||
                         (status_q == `I2CM_ST_RX_ACK) ||
                         (status_q == `I2CM_ST_RX_NACK)) begin
              ack_bit_q <= ctl_ack_enable;
              byte_rx_q <= 1'b1;
              state_q <= S_BYTE;
            end else begin
              slv_q <= 1'b0;
              state_q <= S_LOAD;
            end
          end
        end
        S_LOAD: begin
          if (fifo_valid) begin
            txsh_q <= fifo_data;
            bit_q <= 4'h0;
            phase_q <= `I2CM_PH_LOW;
            if (slv_q) begin
              slv_tx_q <= 1'b1;
              state_q <= S_SLV;
            end else begin
              byte_rx_q <= 1'b0;
              state_q <= S_BYTE;
              if (addr_byte_q) begin
                rx_mode_q <= fifo_data[0];
                ten_q <= (fifo_data[7:3] == `I2CM_TEN_PREFIX) &
                         ~fifo_data[0];
              end
            end
          end
        end
        S_SLV: begin
          if (hold_q) begin
            if (tick) begin
              hold_q <= 1'b0;
            end
          end else if (start_seen || stop_seen) begin
            ack_drv_q <= 1'b0;
            slv_addr_q <= 1'b0;
            state_q <= S_IDLE;
          end else if (scl_rise) begin
            if (bit_q < `I2CM_BIT_ACK) begin
              if (!slv_tx_q) begin
                sh_q <= {sh_q[6:0], sda_s2};
              end
              bit_q <= bit_q + 4'h1;
            end else if (bit_q == `I2CM_BIT_ACK) begin
              ack_rx_q <= ~sda_s2;
              bit_q <= `I2CM_BIT_END;
            end
          end else if (scl_fall) begin
            if ((bit_q == `I2CM_BIT_ACK) && !slv_tx_q) begin
              if (slv_addr_q && !hit[0]) begin
                flag_q <= 1'b1;
                status_q <= `I2CM_ST_ARB;
                slv_addr_q <= 1'b0;
                state_q <= S_WAIT;
              end else if (slv_addr_q) begin
                ack_drv_q <= 1'b1;
                gc_q <= hit[1];
                rx_mode_q <= sh_q[0];
              end else begin
                ack_drv_q <= ack_bit_q;
              end
            end else if (bit_q == `I2CM_BIT_END) begin
              ack_drv_q <= 1'b0;
              flag_q <= 1'b1;
              hold_q <= 1'b1;
              state_q <= S_WAIT;
              if (slv_addr_q) begin
                slv_addr_q <= 1'b0;
                status_q <= rx_mode_q ? `I2CM_ST_SR :
                            (gc_q ? `I2CM_ST_SGC : `I2CM_ST_SW);
              end else if (slv_tx_q) begin
                status_q <= !ack_rx_q ? `I2CM_ST_STX_NACK :
                            (last_q ? `I2CM_ST_STX_LAST :
                             `I2CM_ST_STX_ACK);
              end else begin
                data_q <= sh_q;
                if (gc_q) begin
                  status_q <= ack_bit_q ? `I2CM_ST_GRX_ACK :
                              `I2CM_ST_GRX_NACK;
                end else begin
                  status_q <= ack_bit_q ? `I2CM_ST_SRX_ACK :
                              `I2CM_ST_SRX_NACK;
                end
              end
            end else if (slv_tx_q && (bit_q < `I2CM_BIT_ACK)) begin
              txsh_q <= {txsh_q[6:0], 1'b0};
            end
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
      // software control writes; a written bit beats a hardware clear
      if (ctl_wr) begin
        sta_q <= ctl_start_request;
        stp_q <= ctl_stop_request;
        aak_q <= ctl_ack_enable;
      end
    end
  end

  // outputs
  assign scl_out = low_q;
  assign sda_out = low_q;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;
  assign service_flag = flag_q;
  assign status_code_reg = status_q;
  assign data_byte_reg = data_q;
  assign start_request = sta_q;
  assign stop_request = stp_q;
  assign ack_enable = aak_q;
  assign bus_busy = busy_q;
endmodule // i2cm_ctrl

// File: rtl/i2cm_fifo.v
`timescale 1ns/1ps
`include "i2cm_map.vh"
module i2cm_fifo #(
  parameter WIDTH = `I2CM_FIFO_W,
  parameter DEPTH = `I2CM_FIFO_D,
  parameter AW = `I2CM_FIFO_AW
) (
  input wire clk,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam [31:0] DEPTH_W = DEPTH;
  localparam [AW:0] FULL = DEPTH_W[AW:0];
  localparam [AW:0] NONE = {(AW+1){1'b0}};
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  reg in_ready_q;
  reg out_valid_q;
  wire push;
  wire pop;
  wire [AW:0] cnt_d;

  // flags are registered from the next count, so they match it except in_ready, which reads low during reset
  assign push = in_valid & in_ready_q;
  assign pop = out_valid_q & out_ready;
  assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign in_ready = in_ready_q;
  assign out_valid = out_valid_q;
  assign out_data = mem[rd_q];

  // storage
  always @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // pointers and flags
  always @(posedge clk) begin
    if (!rst_n) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= NONE;
      in_ready_q <= 1'b0;
      out_valid_q <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_d;
      in_ready_q <= (cnt_d != FULL);
      out_valid_q <= (cnt_d != NONE);
    end
  end
endmodule // i2cm_fifo

// File: rtl/i2cm_map.vh
`ifndef I2CM_MAP_VH
`define I2CM_MAP_VH
// timing: system clock and scl period in ns
`define I2CM_CLK_NS 100
`define I2CM_BIT_NS 10000
`define I2CM_QTR_CYC ((`I2CM_BIT_NS / 4) / `I2CM_CLK_NS)
// status codes
`define I2CM_ST_START 8'h08
`define I2CM_ST_RESTART 8'h10
`define I2CM_ST_AW_ACK 8'h18
`define I2CM_ST_AW_NACK 8'h20
`define I2CM_ST_TX_ACK 8'h28
`define I2CM_ST_TX_NACK 8'h30
`define I2CM_ST_ARB 8'h38
`define I2CM_ST_AR_ACK 8'h40
`define I2CM_ST_AR_NACK 8'h48
`define I2CM_ST_RX_ACK 8'h50
`define I2CM_ST_RX_NACK 8'h58
`define I2CM_ST_SW 8'h68
`define I2CM_ST_SGC 8'h78
`define I2CM_ST_SRX_ACK 8'h80
`define I2CM_ST_SRX_NACK 8'h88
`define I2CM_ST_GRX_ACK 8'h90
`define I2CM_ST_GRX_NACK 8'h98
`define I2CM_ST_SR 8'hB0
`define I2CM_ST_STX_ACK 8'hB8
`define I2CM_ST_STX_NACK 8'hC0
`define I2CM_ST_STX_LAST 8'hC8
`define I2CM_ST_XA_ACK 8'hD0
`define I2CM_ST_XA_NACK 8'hD8
`define I2CM_ST_NOINFO 8'hF8
// address fields
`define I2CM_TEN_PREFIX 5'h1E
`define I2CM_GC_ADDR 7'h00
// bit counter marks and bit phases
`define I2CM_BIT_ACK 4'h8
`define I2CM_BIT_END 4'h9
`define I2CM_PH_LOW 2'h0
`define I2CM_PH_RISE 2'h1
`define I2CM_PH_HIGH 2'h2
`define I2CM_PH_FALL 2'h3
// transmit buffer shape
`define I2CM_FIFO_W 8
`define I2CM_FIFO_D 4
`define I2CM_FIFO_AW 2
`endif
